// >>> serial_rx_regs.svh
// offsets, field positions, reset values and timing counts of the receiver
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH
// ********** register map **********
`define ADDR_CTRL     4'h0
`define ADDR_STAT     4'h4
`define CTRL_RESET    7'h48
// ********** control fields **********
`define CF_RATE_LSB   0
`define CF_RATE_MSB   2
`define CF_ELEVEN     3
`define CF_REMOTE     4
`define CF_HS_REV     5
`define CF_BUF_EN     6
// ********** character codes **********
`define CH_BELL       7'h07
`define CH_LF         7'h0A
`define CH_CTRL_N     7'h0E
`define CH_CTRL_O     7'h0F
`define CH_HOME_DOWN  7'h1C
`define CH_RUBOUT     7'h7F
// ********** bit chopper and buffer clock states **********
`define JC_T4         4'hF
`define JC_T5         4'hE
`define JC_T6         4'hC
`define JC_T7         4'h8
`define SB_T1         3'h1
`define SB_T2         3'h3
`define SB_T4         3'h6
`define SB_DEPTH      8
// ********** timing **********
`define CLK_MHZ       10
`define CTL_RST_NS    125
`define CTL_RST_CYC   (((`CTL_RST_NS*`CLK_MHZ)/1000) < 1 ? 1 : \
                       ((`CTL_RST_NS*`CLK_MHZ)/1000))
`define HOME_WIN_US   600
`define BELL_US       66667
`endif

// >>> serial_rx_pkg.sv
// types shared by the receiver files
package serial_rx_pkg;
    // memory timing pulses from the display side
    typedef struct packed {
        logic c1;
        logic c4;
        logic c6;
        logic c7;
    } mem_cycle_t;
    // line pins before synchronising
    typedef struct packed {
        logic rxd;
        logic osc_eleven;
        logic osc_ten;
        logic key_start;
        logic carrier;
        logic rev_channel;
    } line_pins_t;
    // unload transfer phase, gray along the path
    typedef enum logic [1:0] {
        XF_IDLE    = 2'b00,
        XF_MOVED   = 2'b01,
        XF_FLAGGED = 2'b11,
        XF_DONE    = 2'b10
    } xfer_t;
endpackage : serial_rx_pkg

// >>> pin_sync.sv
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 6
) (
    // clocking
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // pins and result
    input  wire logic [W-1:0] pin,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_q, s2_q, s3_q;

    // ********** per-bit chain **********
    for (genvar i = 0; i < W; i++) begin : g_bit
        // stage one feeds only stage two
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_q[i] <= 1'b1;
                s2_q[i] <= 1'b1;
                s3_q[i] <= 1'b1;
                q[i]    <= 1'b1;
            end else if (ce) begin
                s1_q[i] <= pin[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) q[i] <= s3_q[i];
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// >>> serial_receive_interface.sv
// serial receive side: character assembly, control decode, speed buffer
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "serial_rx_regs.svh"
module serial_receive_interface #(
    parameter int unsigned HOME_WIN_CYC = `HOME_WIN_US * `CLK_MHZ,
    parameter int unsigned BELL_CYC     = `BELL_US * `CLK_MHZ
) (
    // clocking
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    // register port
    input  wire logic [3:0]                 addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output var  logic [31:0]                rdata,
    // line pins
    input  wire serial_rx_pkg::line_pins_t  pins,
    // control logic
    input  wire logic                       count64,
    input  wire logic                       scroll_up,
    input  wire logic                       linefeed_busy,
    input  wire logic                       ready_for_data,
    input  wire logic                       memory_ready,
    input  wire logic                       linefeed_accepted,
    input  wire serial_rx_pkg::mem_cycle_t  mem_cycle,
    // outputs
    output var  logic                       char_valid,
    output var  logic [6:0]                 hold_char,
    output var  logic                       spow_flag,
    output var  logic                       bell_enable,
    output var  logic                       rts,
    output var  logic                       home_window
);
    serial_rx_pkg::line_pins_t ps;
    logic [6:0]  ctrl_q, ctrl_d;
    logic        lfa_q, rev_q, car_q, key_q;
    logic [7:0]  div_q, div_d;
    logic        osc_q, osc_d, tick8;
    logic        start_q, start_d, step_q, step_d, ctl_q, ctl_d;
    logic [3:0]  jc_q, jc_d;
    logic [9:0]  sr_q, sr_d;
    logic [6:0]  hold_d;
    logic        flag_d, spow_d, bell_d, home_d, rts_d;
    logic [1:0]  ctl_cnt_q, ctl_cnt_d;
    logic [31:0] home_cnt_q, home_cnt_d, bell_cnt_q, bell_cnt_d;
    logic        armed, t4, t5, t6, t7, is_ctl, rst_class, slow;
    logic [2:0]  sb_q, sb_d;
    logic [7:0]  mem_q [`SB_DEPTH];
    logic [7:0]  mem_d [`SB_DEPTH];
    logic        tagp_q, tagp_d, pend_q, pend_d, lmode_q, lmode_d;
    logic        ldone_q, ldone_d, unl_q, unl_d, tfull_q, tfull_d;
    logic [6:0]  temp_q, temp_d;
    logic        b1, b2, b4, any_tag, take, xfer_ok;
    serial_rx_pkg::xfer_t xf_q, xf_d;

    assign armed = start_q && !sr_q[0];
    assign t4 = step_q && (jc_q == `JC_T4);
    assign t5 = step_q && (jc_q == `JC_T5);
    assign t6 = step_q && (jc_q == `JC_T6);
    assign t7 = step_q && (jc_q == `JC_T7);
    assign is_ctl = (hold_char < 7'h20) || (hold_char == `CH_RUBOUT);
    assign rst_class = is_ctl && (hold_char != 7'h00)
        && (hold_char != `CH_HOME_DOWN) && (hold_char != `CH_LF);
    // home down needs a slow line: 110-440 or 150-300 only
    assign slow = ctrl_q[`CF_ELEVEN] ? (ctrl_q[2:0] <= 3'h2)
                                     : (ctrl_q[2:0] <= 3'h1);

    pin_sync #(.W(6)) u_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .pin (pins),
        .q   (ps)
    );

    // ********** register port **********
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr && addr == `ADDR_CTRL) ctrl_d = wdata[6:0];
    end
    // reads answer one cycle later, unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
            rdata  <= 32'h0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            rdata  <= 32'h0;
            if (rd && addr == `ADDR_CTRL) rdata <= {25'h0, ctrl_q};
            if (rd && addr == `ADDR_STAT)
                rdata <= {17'h0, hold_char, 2'b0, any_tag, tfull_q,
                          start_q, home_window, spow_flag, rts};
        end
    end

    // ********** rate divider **********
    // divisor 256 down to 2 gives 8x of each documented rate
    always_comb begin
        osc_d = ctrl_q[`CF_ELEVEN] ? ps.osc_eleven : ps.osc_ten;
        tick8 = osc_d && !osc_q && (div_q == (8'hFF >> ctrl_q[2:0]));
        div_d = div_q;
        if (osc_d && !osc_q) div_d = tick8 ? 8'h00 : div_q + 8'h01;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 8'h00;
            osc_q <= 1'b0;
        end else if (ce) begin
            div_q <= div_d;
            osc_q <= osc_d;
        end
    end

    // ********** receiver **********
    always_comb begin
        start_d    = start_q;
        jc_d       = jc_q;
        step_d     = 1'b0;
        sr_d       = sr_q;
        hold_d     = hold_char;
        ctl_d      = ctl_q;
        ctl_cnt_d  = ctl_cnt_q;
        flag_d     = 1'b0;
        spow_d     = spow_flag;
        home_d     = home_window;
        home_cnt_d = home_cnt_q;
        bell_d     = bell_enable;
        bell_cnt_d = bell_cnt_q;
        if (!start_q) begin
            sr_d = 10'h3FF;  // input register held in reset
            jc_d = 4'h0;
            if (!ps.rxd) start_d = 1'b1;
        end else if (tick8) begin
            jc_d   = {jc_q[2:0], ~jc_q[3]};
            step_d = 1'b1;
        end
        if (t4) sr_d = {ps.rxd, sr_q[9:1]};
        if (armed && t5 && !ctrl_q[`CF_BUF_EN]) hold_d = sr_q[7:1];
        if (armed && t6 && !ctrl_q[`CF_BUF_EN] && !is_ctl)
            flag_d = 1'b1;
        if (t7) begin
            ctl_d = 1'b0;
            if (armed && sr_q[9]) start_d = 1'b0;
        end
        // buffered transfer moves the temporary character
        if (xf_q == serial_rx_pkg::XF_IDLE && mem_cycle.c7 && xfer_ok)
            hold_d = temp_q;
        if (xf_q == serial_rx_pkg::XF_MOVED && mem_cycle.c1 && !is_ctl)
            flag_d = 1'b1;
        // short decoded pulse for reset-class functions
        if (rst_class && !ctl_q) begin
            ctl_d     = 1'b1;
            ctl_cnt_d = 2'h0;
        end
        if (ctl_q && hold_char != 7'h00) begin
            ctl_cnt_d = ctl_cnt_q + 2'h1;
            if (ctl_cnt_d >= 2'(`CTL_RST_CYC)) hold_d = 7'h00;
        end
        if (ctrl_q[`CF_BUF_EN] && ctl_q && hold_char == 7'h00) ctl_d = 1'b0;
        if (hold_char == `CH_LF && linefeed_accepted && !lfa_q)
            hold_d = 7'h00;
        if (hold_char == `CH_CTRL_N) spow_d = 1'b0;
        if (hold_char == `CH_CTRL_O) spow_d = 1'b1;
        // home down window, dropped outright on fast lines
        if (hold_char == `CH_HOME_DOWN && !home_window) begin
            if (slow) begin
                home_d     = 1'b1;
                home_cnt_d = HOME_WIN_CYC;
            end else begin
                hold_d = 7'h00;
            end
        end
        if (home_window) begin
            home_cnt_d = home_cnt_q - 32'h1;
            if (home_cnt_q <= 32'h1) begin
                home_d = 1'b0;
                hold_d = 7'h00;
            end
        end
        // bell stays on one 7.5 Hz pulse width
        if ((hold_char == `CH_BELL || count64) && !bell_enable) begin
            bell_d     = 1'b1;
            bell_cnt_d = BELL_CYC;
        end else if (bell_enable) begin
            bell_cnt_d = bell_cnt_q - 32'h1;
            if (bell_cnt_q <= 32'h1) bell_d = 1'b0;
        end
        if (bell_enable && hold_char == `CH_BELL) hold_d = 7'h00;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            start_q     <= 1'b0;
            jc_q        <= 4'h0;
            step_q      <= 1'b0;
            sr_q        <= 10'h3FF;
            hold_char   <= 7'h00;
            ctl_q       <= 1'b0;
            ctl_cnt_q   <= 2'h0;
            char_valid  <= 1'b0;
            spow_flag   <= 1'b1;
            home_window <= 1'b0;
            home_cnt_q  <= 32'h0;
            bell_enable <= 1'b0;
            bell_cnt_q  <= 32'h0;
            lfa_q       <= 1'b1;
        end else if (ce) begin
            start_q     <= start_d;
            jc_q        <= jc_d;
            step_q      <= step_d;
            sr_q        <= sr_d;
            hold_char   <= hold_d;
            ctl_q       <= ctl_d;
            ctl_cnt_q   <= ctl_cnt_d;
            char_valid  <= flag_d;
            spow_flag   <= spow_d;
            home_window <= home_d;
            home_cnt_q  <= home_cnt_d;
            bell_enable <= bell_d;
            bell_cnt_q  <= bell_cnt_d;
            lfa_q       <= linefeed_accepted;
        end
    end

    // ********** request to send **********
    // set wins over a same-cycle reverse-channel drop
    always_comb begin
        rts_d = rts;
        if (!ctrl_q[`CF_REMOTE]) rts_d = 1'b0;
        if (ctrl_q[`CF_HS_REV] && rev_q && !ps.rev_channel)
            rts_d = 1'b0;
        if (ctrl_q[`CF_HS_REV] && car_q && !ps.carrier && ctrl_q[`CF_REMOTE])
            rts_d = 1'b1;
        if (ctrl_q[`CF_REMOTE] && ps.key_start && !key_q) rts_d = 1'b1;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rts   <= 1'b0;
            rev_q <= 1'b1;
            car_q <= 1'b1;
            key_q <= 1'b1;
        end else if (ce) begin
            rts   <= rts_d;
            rev_q <= ps.rev_channel;
            car_q <= ps.carrier;
            key_q <= ps.key_start;
        end
    end

    // ********** speed buffer **********
    assign b1 = ctrl_q[`CF_BUF_EN] && (sb_q == `SB_T1);
    assign b2 = ctrl_q[`CF_BUF_EN] && (sb_q == `SB_T2);
    assign b4 = ctrl_q[`CF_BUF_EN] && (sb_q == `SB_T4);
    assign take = unl_q && b4;
    assign xfer_ok = !scroll_up && !linefeed_busy && !ctl_q && tfull_q
        && ready_for_data && !memory_ready && linefeed_accepted;
    // circulating slots; a load only replaces an empty head slot
    for (genvar i = 0; i < `SB_DEPTH; i++) begin : g_slot
        if (i == `SB_DEPTH - 1) begin : g_tail
            assign mem_d[i] = b1 ? ((lmode_q && !mem_q[0][7])
                ? {1'b1, sr_q[7:1]} : mem_q[0]) : mem_q[i];
        end else if (i == 0) begin : g_head
            assign mem_d[i] = b1 ? mem_q[1]
                : (take ? {1'b0, mem_q[0][6:0]} : mem_q[0]);
        end else begin : g_mid
            assign mem_d[i] = b1 ? mem_q[i+1] : mem_q[i];
        end
    end
    always_comb begin
        any_tag = 1'b0;
        for (int k = 0; k < `SB_DEPTH; k++) any_tag = any_tag | mem_q[k][7];
        sb_d    = ctrl_q[`CF_BUF_EN] ? {sb_q[1:0], ~sb_q[2]} : 3'h0;
        tagp_d  = b1 ? mem_q[0][7] : tagp_q;
        pend_d  = pend_q;
        lmode_d = lmode_q;
        ldone_d = start_q ? ldone_q : 1'b0;
        unl_d   = unl_q;
        tfull_d = tfull_q;
        temp_d  = temp_q;
        xf_d    = xf_q;
        if (ctrl_q[`CF_BUF_EN] && armed && !ldone_q && !pend_q && !lmode_q
            && ((b2 && tagp_q && !mem_q[0][7]) || (t5 && !any_tag)))
            pend_d = 1'b1;
        if (pend_q && b4) begin
            pend_d  = 1'b0;
            lmode_d = 1'b1;
        end
        if (lmode_q && b2) begin
            lmode_d = 1'b0;
            ldone_d = 1'b1;
        end
        if (b2 && !tagp_q && mem_q[0][7] && !tfull_q) unl_d = 1'b1;
        if (take) begin
            unl_d   = 1'b0;
            tfull_d = 1'b1;
            temp_d  = mem_q[0][6:0];
        end
        unique case (xf_q)
            serial_rx_pkg::XF_IDLE:
                if (mem_cycle.c7 && xfer_ok) xf_d = serial_rx_pkg::XF_MOVED;
            serial_rx_pkg::XF_MOVED:
                if (mem_cycle.c1) begin
                    xf_d    = serial_rx_pkg::XF_FLAGGED;
                    tfull_d = 1'b0;
                end
            serial_rx_pkg::XF_FLAGGED:
                if (mem_cycle.c4) xf_d = serial_rx_pkg::XF_DONE;
            serial_rx_pkg::XF_DONE:
                if (mem_cycle.c6) xf_d = serial_rx_pkg::XF_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            sb_q    <= 3'h0;
            for (int k = 0; k < `SB_DEPTH; k++) mem_q[k] <= 8'h00;
            tagp_q  <= 1'b0;
            pend_q  <= 1'b0;
            lmode_q <= 1'b0;
            ldone_q <= 1'b0;
            unl_q   <= 1'b0;
            tfull_q <= 1'b0;
            temp_q  <= 7'h00;
            xf_q    <= serial_rx_pkg::XF_IDLE;
        end else if (ce) begin
            sb_q    <= sb_d;
            for (int k = 0; k < `SB_DEPTH; k++) mem_q[k] <= mem_d[k];
            tagp_q  <= tagp_d;
            pend_q  <= pend_d;
            lmode_q <= lmode_d;
            ldone_q <= ldone_d;
            unl_q   <= unl_d;
            tfull_q <= tfull_d;
            temp_q  <= temp_d;
            xf_q    <= xf_d;
        end
    end

    // ********** checks **********
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);
    sequence s_move;
        xf_q == serial_rx_pkg::XF_IDLE && mem_cycle.c7 && xfer_ok;
    endsequence
    AST_START: assert property (!start_q && !ps.rxd |=> start_q)
        else $error("start latch not set");
    AST_SHIFT: assert property (t4 |=> sr_q == {$past(ps.rxd), $past(sr_q[9:1])})
        else $error("input register did not shift");
    AST_LOAD: assert property (armed && t5 && !ctrl_q[`CF_BUF_EN] |=> hold_char == $past(sr_q[7:1]))
        else $error("hold register not loaded");
    AST_NOFLAG: assert property (armed && t6 && is_ctl && xf_q != serial_rx_pkg::XF_MOVED |=> !char_valid)
        else $error("flag on control character");
    AST_SYNC: assert property (start_q && t7 && !(armed && sr_q[9]) |=> start_q)
        else $error("start latch lost sync");
    AST_CTLCLR: assert property (rst_class && !take ##1 !take |=> hold_char == 7'h00)
        else $error("control not cleared");
    AST_SPOW: assert property (hold_char == `CH_CTRL_N |=> !spow_flag)
        else $error("overwrite flag not cleared");
    AST_HOMEDROP: assert property (hold_char == `CH_HOME_DOWN && !home_window && !slow |=> hold_char == 7'h00)
        else $error("home down kept on a fast line");
    AST_BELL: assert property (count64 |=> bell_enable)
        else $error("bell not started");
    AST_RTSDROP: assert property (ctrl_q[`CF_HS_REV] && rev_q && !ps.rev_channel && !(ps.key_start && !key_q) && !(car_q && !ps.carrier) |=> !rts)
        else $error("request-to-send not dropped");
    AST_XFER: assert property (s_move |=> xf_q == serial_rx_pkg::XF_MOVED && hold_char == $past(temp_q) ##[1:1000] (xf_q == serial_rx_pkg::XF_FLAGGED && !tfull_q))
        else $error("transfer sequence broken");
endmodule : serial_receive_interface
`default_nettype wire

// >>> modem_model.sv
// far-side data set: bit-rate crystals, serial frames, turnaround lines
`timescale 1ns/10ps
`default_nettype none
module modem_model #(
    parameter int BIT_EDGES = 128
) (
    // line toward the receiver
    output var logic rxd,
    output var logic osc_ten,
    output var logic osc_eleven,
    output var logic carrier,
    output var logic rev_channel
);
    // crystals run free and unrelated to the system clock
    initial begin
        osc_ten = 1'b0;
        osc_eleven = 1'b0;
        rxd = 1'b1;
        carrier = 1'b1;
        rev_channel = 1'b1;
    end
    always #400 osc_ten = ~osc_ten;
    always #470 osc_eleven = ~osc_eleven;

    // one ten-bit frame, lsb first, even parity, line rests at mark
    task automatic send_char(input logic [6:0] c);
        logic [9:0] f;
        f = {1'b1, ^c, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge osc_ten);
            rxd = f[i];
            repeat (BIT_EDGES - 1) @(posedge osc_ten);
        end
        repeat (BIT_EDGES / 2) @(posedge osc_ten);
    endtask : send_char

    // remote end steers request-to-send through these two lines
    task automatic turn(input logic rev, input logic car);
        rev_channel = rev;
        carrier = car;
    endtask : turn
endmodule : modem_model
`default_nettype wire

// >>> test_serial_receive_interface.sv
// self-checking bench for the serial receive interface
`timescale 1ns/10ps
`default_nettype none
module test_serial_receive_interface;
    // **********************************
    // stimulus, design and data set
    // **********************************
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic        key_start = 1'b0;
    logic        count64 = 1'b0;
    logic        scroll_up = 1'b0;
    logic        linefeed_busy = 1'b0;
    logic        ready_for_data = 1'b1;
    logic        memory_ready = 1'b0;
    logic        linefeed_accepted = 1'b1;
    logic [2:0]  mc_q = 3'h0;
    logic [31:0] rdata;
    logic        rxd, osc11, osc10, carrier, rev_ch;
    logic        char_valid, spow_flag, bell_enable, rts, home_window;
    logic [6:0]  hold_char, c1, c2;
    logic [6:0]  ctl [4] = '{7'h0E, 7'h0F, 7'h07, 7'h1C};
    logic [31:0] exq [$];
    logic [6:0]  chq [$];
    int          n_fail = 0;
    int          total_checks = 0;
    int          bell_hi = 0;
    serial_rx_pkg::mem_cycle_t mem_cycle = 4'h0;
    serial_rx_pkg::line_pins_t pins;

    assign pins = {rxd, osc11, osc10, key_start, carrier, rev_ch};
    always #50 clk = ~clk;

    serial_receive_interface #(.HOME_WIN_CYC(50), .BELL_CYC(20))
        serial_receive_interface_inst (
        .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pins(pins), .count64(count64),
        .scroll_up(scroll_up), .linefeed_busy(linefeed_busy),
        .ready_for_data(ready_for_data), .memory_ready(memory_ready),
        .linefeed_accepted(linefeed_accepted), .mem_cycle(mem_cycle),
        .char_valid(char_valid), .hold_char(hold_char),
        .spow_flag(spow_flag), .bell_enable(bell_enable), .rts(rts),
        .home_window(home_window));

    modem_model modem_model_inst (
        .rxd(rxd), .osc_ten(osc10), .osc_eleven(osc11),
        .carrier(carrier), .rev_channel(rev_ch));

    // **********************************
    // tasks
    // **********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // expected word is queued; the monitor compares it a cycle later
    task automatic rd_exp(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_exp

    // pins pass a three-flop synchroniser, so allow a dozen cycles
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask : settle

    task automatic drain();
        int i;
        for (i = 0; i < 4000 && chq.size() != 0; i++) @(posedge clk);
        if (chq.size() != 0) begin
            $display("mismatch at %0t: flags never came", $time);
            n_fail++;
            close_out();
        end
    endtask : drain

    // memory cycle pulses every seven clocks; bell width counter
    always @(posedge clk) begin
        rd_d <= rd;
        mc_q <= (mc_q == 3'h6) ? 3'h0 : mc_q + 3'h1;
        mem_cycle <= {mc_q == 3'h0, mc_q == 3'h3, mc_q == 3'h5, mc_q == 3'h6};
        if (bell_enable === 1'b1) bell_hi <= bell_hi + 1;
    end

    // results taken off the queues mid-cycle, where they are settled
    always @(negedge clk) begin
        if (rd_d) check(rdata, exq.pop_front());
        if (char_valid === 1'b1) begin
            if (chq.size() == 0) check(char_valid, 32'h0);
            else check(hold_char, chq.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        $display("mismatch at %0t: run too long", $time);
        n_fail++;
        close_out();
    end

    // **********************************
    // scenarios
    // **********************************
    initial begin
        void'($urandom(85));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_exp(4'h0, 32'h48);
        rd_exp(4'h4, 32'h2);
        rd_exp(4'h8, 32'h0);
        wr_reg(4'h0, 32'h34);
        rd_exp(4'h0, 32'h34);
        // turnaround: key start, reverse channel, carrier, back to local
        key_start <= 1'b1;
        settle();
        check(rts, 32'h1);
        key_start <= 1'b0;
        modem_model_inst.turn(1'b0, 1'b1);
        settle();
        check(rts, 32'h0);
        modem_model_inst.turn(1'b1, 1'b0);
        settle();
        check(rts, 32'h1);
        modem_model_inst.turn(1'b1, 1'b1);
        wr_reg(4'h0, 32'h04);
        settle();
        check(rts, 32'h0);
        // direct reception, printable then control codes
        chq.push_back(7'h41);
        modem_model_inst.send_char(7'h41);
        rd_exp(4'h4, 32'h4102);
        for (int i = 0; i < 4; i++) begin
            modem_model_inst.send_char(ctl[i]);
            check(spow_flag, i != 0);
            check(home_window, 32'h0);
        end
        check(bell_hi, 32'd20);
        count64 <= 1'b1;
        @(posedge clk);
        count64 <= 1'b0;
        repeat (30) @(posedge clk);
        check(bell_hi, 32'd40);
        // speed buffer: two characters held back, then released in order
        wr_reg(4'h0, 32'h44);
        ready_for_data <= 1'b0;
        c1 = 7'h20 + 7'($urandom % 95);
        c2 = 7'h20 + 7'($urandom % 95);
        modem_model_inst.send_char(c1);
        modem_model_inst.send_char(c2);
        rd_exp(4'h4, 32'h32);
        // ready, but a scroll and then a busy memory still hold it back
        scroll_up <= 1'b1;
        ready_for_data <= 1'b1;
        repeat (20) @(posedge clk);
        scroll_up <= 1'b0;
        memory_ready <= 1'b1;
        repeat (20) @(posedge clk);
        rd_exp(4'h4, 32'h32);
        chq.push_back(c1);
        chq.push_back(c2);
        memory_ready <= 1'b0;
        drain();
        rd_exp(4'h4, {17'h0, c2, 8'h02});
        repeat (2) @(posedge clk);
        close_out();
    end
endmodule : test_serial_receive_interface
`default_nettype wire
